// [rtl/modbus_map_pkg.sv]
// package: constants and carriers for the modbus server function decoder
package modbus_map_pkg;

  // =====================================================================
  // function codes
  localparam logic [7:0] FC_READ_COILS      = 8'h01;
  localparam logic [7:0] FC_READ_DISCRETE   = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING    = 8'h03;
  localparam logic [7:0] FC_READ_INPUT      = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL      = 8'h05;
  localparam logic [7:0] FC_WRITE_REG       = 8'h06;
  localparam logic [7:0] FC_DIAGNOSTICS     = 8'h08;
  localparam logic [7:0] FC_WRITE_COILS     = 8'h0f;
  localparam logic [7:0] FC_WRITE_REGS      = 8'h10;
  localparam logic [7:0] FC_READ_WRITE_REGS = 8'h17;
  localparam logic [7:0] EXC_FLAG           = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC   = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR   = 8'h02;

  // =====================================================================
  // diagnostics subcodes
  localparam logic [15:0] DIAG_QUERY        = 16'h0000;
  localparam logic [15:0] DIAG_RESTART      = 16'h0001;
  localparam logic [15:0] DIAG_LISTEN_ONLY  = 16'h0004;

  // =====================================================================
  // reference map, zero based addresses
  localparam logic [15:0] COIL_CTRL_LAST    = 16'h001f;
  localparam logic [15:0] COIL_RELAY_BASE   = 16'h0020;
  localparam int          RELAY_COUNT       = 6;
  localparam logic [15:0] DIN_STATUS_LAST   = 16'h001f;
  localparam logic [15:0] DIN_TERM_BASE     = 16'h0020;
  localparam int          TERM_COUNT        = 6;
  localparam int          ANALOG_COUNT      = 2;
  localparam int          HOLD_DEPTH        = 64;
  localparam int          HOLD_AW           = 6;
  localparam logic [15:0] HOLD_CTRL_ADDR    = 16'h0000;
  localparam logic [15:0] HOLD_PROFILE_ADDR = 16'h0001;
  localparam logic [15:0] HOLD_SYSCTL_ADDR  = 16'h0002;
  localparam logic [15:0] HOLD_STATUS_ADDR  = 16'h0003;

  // =====================================================================
  // profiles
  localparam logic [15:0] PROF_LIMITED      = 16'h0000;
  localparam logic [15:0] PROF_EXTENDED     = 16'h0001;
  localparam logic [15:0] PROF_FULL         = 16'h0002;
  localparam logic [15:0] SYSCTL_SYSTEM     = 16'h0001;
  localparam logic [31:0] MASK_LIMITED      = 32'h0000_08ef;
  localparam logic [31:0] MASK_FULL         = 32'h0000_0cff;
  localparam logic [31:0] MASK_EXTENDED     = 32'h000f_ffff;
  localparam logic [31:0] MASK_BYPASS       = 32'h0000_ffff;

  typedef enum logic [1:0] {
    limited_drive_profile,
    extended_32bit_profile,
    full_drive_profile,
    fixed_bypass_profile
  } profile_t;

  // =====================================================================
  // request: one decoded message; count is coil or register count
  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] count;
    logic [15:0] data;
    logic [15:0] waddr;
    logic [15:0] wcount;
  } request_t;

  // reply word stream: header then data words
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [15:0] word;
  } reply_t;

endpackage

// [rtl/modbus_rtu_server_map.sv]
// modbus rtu server function decoder mapping requests onto drive resources
//
// Summary of operation
// R1 - reply only to client requests, half duplex
// R2 - framing below assumes rtu binary mode
// R3 - read coils returns control word bits
// R4 - relay outputs start at coil 33
// R5 - force single coil, same coil map
// R6 - force multiple coils, same coil map
// R7 - discrete inputs give status word bits
// R8 - terminal inputs start at input 33
// R9 - two analog inputs as input registers
// R10 - read consecutive holding registers
// R11 - write one holding register
// R12 - write consecutive holding registers
// R13 - combined write then read registers
// R14 - diagnostics echo, restart, listen only
// R15 - profile parameter selects control profile
// R16 - system control forces bypass profile
// R17 - limited drive profile after reset
// R18 - extended profile widens words to 32 (the control word mask passes bits 0 to 19 only)
// R19 - full profile enables two extra bits
// R20 - message addresses are zero based
// R21 - unsupported function gives illegal function
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module modbus_rtu_server_map
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  input  wire logic                        clk_en,
  // request from rtu framer, one cycle strobe (see R2)
  input  wire logic                        req_valid,
  input  wire modbus_map_pkg::request_t    req,
  // write data words for multi writes, each held until taken with wdata_ready
  input  wire logic                        wdata_valid,
  input  wire logic [15:0]                 wdata,
  output logic                             wdata_ready,
  // reply word stream to framer
  output modbus_map_pkg::reply_t           reply,
  output logic                             busy,
  output logic                             listen_only,
  output logic                             comm_restart,
  // drive resources
  input  wire logic [31:0]                 status_word,
  input  wire logic [modbus_map_pkg::TERM_COUNT-1:0] term_in_pin,
  input  wire logic [15:0]                 analog_in0,
  input  wire logic [15:0]                 analog_in1,
  output logic [31:0]                      control_word,
  output logic [modbus_map_pkg::RELAY_COUNT-1:0] relay_out,
  output modbus_map_pkg::profile_t         profile
);

  // =====================================================================
  // state
  typedef enum logic [2:0] {
    st_idle,
    st_wcoils,
    st_wregs,
    st_head,
    st_rbits,
    st_rregs,
    st_done
  } state_t;

  state_t                                  state;
  modbus_map_pkg::request_t                cur;
  logic [15:0]                             ptr;
  logic [15:0]                             left;
  logic [15:0]                             hold [modbus_map_pkg::HOLD_DEPTH];
  logic [modbus_map_pkg::TERM_COUNT-1:0]   term_meta;
  logic [modbus_map_pkg::TERM_COUNT-1:0]   term_sync;
  logic [3:0]                              bitpos;
  logic [15:0]                             bitacc;

  // term pins come from outside: two flops first
  always_ff @(posedge clk_sys)
  begin
    if (clk_en)
    begin
      term_meta <= term_in_pin;
      term_sync <= term_meta;
    end
  end

  // =====================================================================
  // profile selection
  wire logic [15:0] prof_par  = hold[modbus_map_pkg::HOLD_PROFILE_ADDR[5:0]];
  wire logic [15:0] sysctl    = hold[modbus_map_pkg::HOLD_SYSCTL_ADDR[5:0]];
  wire logic        sys_byp   = (sysctl == modbus_map_pkg::SYSCTL_SYSTEM);
  wire modbus_map_pkg::profile_t next_profile =
    sys_byp ? modbus_map_pkg::fixed_bypass_profile :             // see R16
    (prof_par == modbus_map_pkg::PROF_EXTENDED) ?
      modbus_map_pkg::extended_32bit_profile :                   // see R15
    (prof_par == modbus_map_pkg::PROF_FULL) ?
      modbus_map_pkg::full_drive_profile :
      modbus_map_pkg::limited_drive_profile;                     // see R17
  // bits the active profile honours; full adds bits 4 and 10
  wire logic [31:0] ctrl_mask =
    (profile == modbus_map_pkg::extended_32bit_profile) ?
      modbus_map_pkg::MASK_EXTENDED :                            // see R18
    (profile == modbus_map_pkg::full_drive_profile) ?
      modbus_map_pkg::MASK_FULL :                                // see R19
    (profile == modbus_map_pkg::fixed_bypass_profile) ?
      modbus_map_pkg::MASK_BYPASS : modbus_map_pkg::MASK_LIMITED;
  wire logic        wide      =
    (profile == modbus_map_pkg::extended_32bit_profile);         // see R18
  wire logic [31:0] stat_vis  =
    wide ? status_word : {16'h0000, status_word[15:0]};          // see R7

  // =====================================================================
  // bit and register lookup, addresses zero based (see R20)
  function automatic logic coil_bit(input logic [15:0] a);
    logic [15:0] r;
    r = a - modbus_map_pkg::COIL_RELAY_BASE;
    if (a <= modbus_map_pkg::COIL_CTRL_LAST)
      coil_bit = control_word[a[4:0]];                           // see R3
    else if (r < 16'(modbus_map_pkg::RELAY_COUNT))
      coil_bit = relay_out[r[2:0]];                              // see R4
    else
      coil_bit = 1'b0;
  endfunction

  function automatic logic din_bit(input logic [15:0] a);
    logic [15:0] r;
    r = a - modbus_map_pkg::DIN_TERM_BASE;
    if (a <= modbus_map_pkg::DIN_STATUS_LAST)
      din_bit = stat_vis[a[4:0]];                                // see R7
    else if (r < 16'(modbus_map_pkg::TERM_COUNT))
      din_bit = term_sync[r[2:0]];                               // see R8
    else
      din_bit = 1'b0;
  endfunction

  wire logic        is_coil_rd = (cur.func == modbus_map_pkg::FC_READ_COILS);
  wire logic        cur_bit    = is_coil_rd ? coil_bit(ptr) : din_bit(ptr);
  wire logic [15:0] hold_word  =
    (ptr == modbus_map_pkg::HOLD_STATUS_ADDR) ? stat_vis[15:0] :
    hold[ptr[modbus_map_pkg::HOLD_AW-1:0]];                      // see R10
  wire logic [15:0] in_word    = ptr[0] ? analog_in1 : analog_in0; // see R9
  wire logic [15:0] reg_word   =
    (cur.func == modbus_map_pkg::FC_READ_INPUT) ? in_word : hold_word;

  // =====================================================================
  // request classification
  wire logic f_rbits  = (req.func == modbus_map_pkg::FC_READ_COILS) ||
                        (req.func == modbus_map_pkg::FC_READ_DISCRETE);
  wire logic f_rhold  = (req.func == modbus_map_pkg::FC_READ_HOLDING);
  wire logic f_rin    = (req.func == modbus_map_pkg::FC_READ_INPUT);
  wire logic f_wcoil  = (req.func == modbus_map_pkg::FC_WRITE_COIL);
  wire logic f_wreg   = (req.func == modbus_map_pkg::FC_WRITE_REG);
  wire logic f_diag   = (req.func == modbus_map_pkg::FC_DIAGNOSTICS);
  wire logic f_wcoils = (req.func == modbus_map_pkg::FC_WRITE_COILS);
  wire logic f_wregs  = (req.func == modbus_map_pkg::FC_WRITE_REGS);
  wire logic f_rw     = (req.func == modbus_map_pkg::FC_READ_WRITE_REGS);
  wire logic f_known  = f_rbits | f_rhold | f_rin | f_wcoil | f_wreg |
                        f_diag | f_wcoils | f_wregs | f_rw;
  wire logic in_range = f_rin ?
    (32'(req.addr) + 32'(req.count) <= 32'(modbus_map_pkg::ANALOG_COUNT)) :
    1'b1;
  wire logic hold_ok  =
    (32'(req.addr) + 32'(req.count) <= 32'(modbus_map_pkg::HOLD_DEPTH));
  wire logic w_ok     = f_wreg ? (req.addr < 16'(modbus_map_pkg::HOLD_DEPTH))
                      : (f_wregs | f_rw) ?
    (32'(req.waddr) + 32'(req.wcount) <= 32'(modbus_map_pkg::HOLD_DEPTH)) :
    1'b1;
  wire logic addr_ok  = in_range && w_ok && (!(f_rhold | f_rw) || hold_ok);
  wire logic take     = clk_en && req_valid && (state == st_idle);

  // coil value for 0x05 is ff00 on, 0000 off
  wire logic        wcoil_val = (req.data == 16'hff00);
  wire logic [15:0] wcoil_adr = cur.waddr + {12'h000, bitpos};

  // =====================================================================
  // sequencer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state        <= st_idle;
      cur          <= '0;
      ptr          <= 16'h0000;
      left         <= 16'h0000;
      bitpos       <= 4'h0;
      bitacc       <= 16'h0000;
      reply        <= '0;
      busy         <= 1'b0;
      wdata_ready  <= 1'b0;
      listen_only  <= 1'b0;
      comm_restart <= 1'b0;
      control_word <= 32'h0000_0000;
      relay_out    <= '0;
      profile      <= modbus_map_pkg::limited_drive_profile;     // see R17
      for (int i = 0; i < modbus_map_pkg::HOLD_DEPTH; i++)
        hold[i] <= 16'h0000;
    end
    else if (clk_en)
    begin
      profile      <= next_profile;
      reply        <= '0;
      comm_restart <= 1'b0;
      case (state)
        st_idle:
        begin
          busy <= 1'b0;
          if (req_valid)                                         // see R1
          begin
            cur   <= req;
            busy  <= 1'b1;
            state <= st_done;
            if (!f_known)
            begin
              // no state change, exception only
              reply <= '{1'b1, 1'b1,
                {req.func | modbus_map_pkg::EXC_FLAG,
                 modbus_map_pkg::EXC_ILLEGAL_FUNC}};             // see R21
            end
            else if (!addr_ok)
              reply <= '{1'b1, 1'b1,
                {req.func | modbus_map_pkg::EXC_FLAG,
                 modbus_map_pkg::EXC_ILLEGAL_ADDR}};
            else if (f_diag)
            begin
              reply <= '{1'b1, 1'b1, req.data};                  // see R14
              if (req.addr == modbus_map_pkg::DIAG_RESTART)
              begin
                listen_only  <= 1'b0;
                comm_restart <= 1'b1;
              end
              else if (req.addr == modbus_map_pkg::DIAG_LISTEN_ONLY)
                listen_only <= 1'b1;
            end
            else if (f_wcoil)
            begin
              if (req.addr <= modbus_map_pkg::COIL_CTRL_LAST)
                control_word[req.addr[4:0]] <=
                  wcoil_val & ctrl_mask[req.addr[4:0]];          // see R5
              else if (req.addr - modbus_map_pkg::COIL_RELAY_BASE <
                       16'(modbus_map_pkg::RELAY_COUNT))
                relay_out[3'(req.addr - modbus_map_pkg::COIL_RELAY_BASE)] <=
                  wcoil_val;                                     // see R5
              reply <= '{1'b1, 1'b1, req.addr};
            end
            else if (f_wreg)
            begin
              hold[req.addr[modbus_map_pkg::HOLD_AW-1:0]] <= req.data; // see R11
              if (req.addr == modbus_map_pkg::HOLD_CTRL_ADDR)
                control_word[15:0] <= req.data & ctrl_mask[15:0];
              reply <= '{1'b1, 1'b1, req.data};
            end
            else if (f_wcoils)
            begin
              cur.waddr <= req.addr;
              left      <= req.count;
              bitpos    <= 4'h0;
              wdata_ready <= (req.count == 16'h0001);
              state     <= st_wcoils;
            end
            else if (f_wregs | f_rw)
            begin
              left      <= f_rw ? req.wcount : req.count;
              ptr       <= f_rw ? req.waddr : req.addr;
              wdata_ready <= 1'b1;
              state     <= st_wregs;
            end
            else
            begin
              ptr   <= req.addr;
              left  <= req.count;
              state <= st_head;
            end
          end
        end
        st_wcoils:
        begin
          // one data word carries sixteen coils, lsb first
          if (left == 16'h0000)
          begin
            wdata_ready <= 1'b0;
            reply <= '{1'b1, 1'b1, cur.count};
            state <= st_done;
          end
          else if (wdata_valid)
          begin
            if (wcoil_adr <= modbus_map_pkg::COIL_CTRL_LAST)
              control_word[wcoil_adr[4:0]] <=
                wdata[bitpos] & ctrl_mask[wcoil_adr[4:0]];       // see R6
            else if (wcoil_adr - modbus_map_pkg::COIL_RELAY_BASE <
                     16'(modbus_map_pkg::RELAY_COUNT))
              relay_out[3'(wcoil_adr - modbus_map_pkg::COIL_RELAY_BASE)] <=
                wdata[bitpos];                                   // see R6
            left   <= left - 16'h0001;
            bitpos <= bitpos + 4'h1;
            if (bitpos == 4'hf)
              cur.waddr <= cur.waddr + 16'h0010;
            // ready only beside the last coil of a word, which pops it
            wdata_ready <= (left == 16'h0002) ||
                           (bitpos == 4'he && left != 16'h0001);
          end
        end
        st_wregs:
        begin
          if (left == 16'h0000)
          begin
            wdata_ready <= 1'b0;
            if (cur.func == modbus_map_pkg::FC_READ_WRITE_REGS)
            begin
              ptr   <= cur.addr;                                 // see R13
              left  <= cur.count;
              state <= st_head;
            end
            else
            begin
              reply <= '{1'b1, 1'b1, cur.count};
              state <= st_done;
            end
          end
          else if (wdata_valid)
          begin
            hold[ptr[modbus_map_pkg::HOLD_AW-1:0]] <= wdata;     // see R12
            if (ptr == modbus_map_pkg::HOLD_CTRL_ADDR)
              control_word[15:0] <= wdata & ctrl_mask[15:0];
            ptr  <= ptr + 16'h0001;
            left <= left - 16'h0001;
          end
        end
        st_head:
        begin
          // header word holds the data word count
          reply  <= '{1'b1, left == 16'h0000,
            (cur.func == modbus_map_pkg::FC_READ_COILS ||
             cur.func == modbus_map_pkg::FC_READ_DISCRETE) ?
              ((left + 16'h000f) >> 4) : left};
          bitpos <= 4'h0;
          bitacc <= 16'h0000;
          state  <= (left == 16'h0000) ? st_done :
            (cur.func == modbus_map_pkg::FC_READ_COILS ||
             cur.func == modbus_map_pkg::FC_READ_DISCRETE) ?
              st_rbits : st_rregs;
        end
        st_rbits:
        begin
          // pack bits lsb first, sixteen to a word
          bitacc[bitpos] <= cur_bit;                             // see R3
          ptr    <= ptr + 16'h0001;
          left   <= left - 16'h0001;
          bitpos <= bitpos + 4'h1;
          if (bitpos == 4'hf || left == 16'h0001)
          begin
            reply  <= '{1'b1, left == 16'h0001,
              bitacc | (16'(cur_bit) << bitpos)};
            bitacc <= 16'h0000;
            bitpos <= 4'h0;
            if (left == 16'h0001)
              state <= st_done;
          end
        end
        st_rregs:
        begin
          reply <= '{1'b1, left == 16'h0001, reg_word};          // see R10
          ptr   <= ptr + 16'h0001;
          left  <= left - 16'h0001;
          if (left == 16'h0001)
            state <= st_done;
        end
        st_done:
        begin
          busy  <= 1'b0;
          state <= st_idle;
        end
        default:
          state <= st_idle;
      endcase
      // listen only: actions done, replies suppressed except to a diagnostics restart (see R14)
      if (listen_only && !(take && f_diag &&
          req.addr == modbus_map_pkg::DIAG_RESTART))
        reply.valid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [tb/modbus_map_properties.sv]
// checker: port timing and state properties of the modbus decoder
`timescale 1ns/1ps
`default_nettype none
module modbus_map_properties
(
  input wire logic                     clk_sys,
  input wire logic                     rst_b,
  input wire logic                     clk_en,
  input wire logic                     req_valid,
  input wire modbus_map_pkg::request_t req,
  input wire modbus_map_pkg::reply_t   reply,
  input wire logic                     busy,
  input wire logic                     listen_only,
  input wire logic                     comm_restart,
  input wire logic [31:0]              control_word,
  input wire logic [5:0]               relay_out,
  input wire modbus_map_pkg::profile_t profile
);
  // =====================================================================
  // request take, as the client sees it: idle for two cycles
  logic       idle_d;
  wire  [7:0] fn   = req.func;
  wire        take = req_valid && clk_en && !busy && idle_d;
  wire        talk = take && !listen_only;
  wire        rd   = fn inside {8'h01, 8'h02, 8'h03, 8'h04};
  wire        bad  = !(rd || fn inside {8'h05, 8'h06, 8'h08, 8'h0f,
                                        8'h10, 8'h17});
  always_ff @(posedge clk_sys)
    idle_d <= rst_b && !busy;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // =====================================================================
  // properties
  a_exc_word: assert property (
    talk && bad |=> reply.valid && reply.word == {($past(fn) | 8'h80), 8'h01})
    else $error("exception reply wrong");
  a_illegal_still: assert property (
    take && bad |=> ($stable(control_word) && $stable(relay_out)
                     && $stable(profile))[*2])
    else $error("illegal function changed state");
  a_single_reply: assert property (
    talk && fn inside {8'h05, 8'h06} |=> reply.valid)
    else $error("single reply late");
  a_read_header: assert property (
    talk && rd |=> !reply.valid ##1 reply.valid)
    else $error("read header not two cycles after take");
  a_listen_quiet: assert property (
    take && listen_only && fn != 8'h08 |=> !reply.valid [*4])
    else $error("reply while listening only");
  a_restart_pulse: assert property (
    take && fn == 8'h08 && req.addr == 16'h0001
    |-> ##[1:2] comm_restart ##1 !comm_restart)
    else $error("restart pulse missing");
  a_freeze_hold: assert property (
    !clk_en |=> $stable(control_word) && $stable(relay_out))
    else $error("state moved while frozen");
  a_reset_state: assert property (disable iff (1'b0)
    !rst_b && clk_en |=> control_word == 32'h0 && !listen_only
    && profile == modbus_map_pkg::limited_drive_profile)
    else $error("reset state wrong");
  c_rw: cover property (take && fn == 8'h17);
  c_listen: cover property (take && listen_only);
  c_exc: cover property (talk && bad);
endmodule
bind modbus_rtu_server_map modbus_map_properties modbus_map_properties_inst
  (.clk_sys, .rst_b, .clk_en, .req_valid, .req, .reply, .busy, .listen_only,
   .comm_restart, .control_word, .relay_out, .profile);
`default_nettype wire

// [tb/client_model.sv]
// client model: sends requests, feeds write words, gathers replies
`timescale 1ns/1ps
`default_nettype none
module client_model
(
  input  wire logic                   clk_sys,
  output logic                        req_valid,
  output modbus_map_pkg::request_t    req,
  output logic                        wdata_valid,
  output logic [15:0]                 wdata,
  input  wire logic                   wdata_ready,
  input  wire modbus_map_pkg::reply_t reply,
  input  wire logic                   busy,
  input  wire logic                   comm_restart
);
  logic [15:0] wq[$];
  logic [15:0] got[$];
  logic        saw_restart;
  initial
  begin
    req_valid   = 1'b0;
    req         = '0;
    wdata_valid = 1'b0;
    wdata       = 16'h0000;
  end
  // =====================================================================
  // write words held until taken; released lines flip so stale data shows
  always @(posedge clk_sys)
  begin
    if (wdata_valid && wdata_ready)
      void'(wq.pop_front());
    wdata_valid <= wq.size() != 0;
    wdata       <= wq.size() != 0 ? wq[0] : ~wdata;
  end
  // only the client opens a transaction, binary frames, one at a time
  task automatic issue(input modbus_map_pkg::request_t r);
    int n;
    n = 0;
    got.delete();
    saw_restart = 1'b0;
    while (busy && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req       <= r;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req       <= ~r;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk_sys);
      saw_restart |= comm_restart;
      if (reply.valid)
        got.push_back(reply.word);
      if (reply.valid && reply.last)
        n = 40;
    end
    @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// [tb/modbus_rtu_server_map_tb.sv]
// testbench: scenarios for the modbus server function decoder
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_server_map_tb;
  logic                     clk_sys, rst_b, clk_en, req_valid, busy;
  logic                     wdata_valid, wdata_ready;
  logic                     listen_only, comm_restart;
  logic [15:0]              wdata, analog_in0, analog_in1;
  logic [31:0]              status_word, control_word;
  logic [5:0]               term_in_pin, relay_out;
  modbus_map_pkg::request_t req;
  modbus_map_pkg::reply_t   reply;
  modbus_map_pkg::profile_t profile;
  int                       n_fail, checks_done;
  modbus_rtu_server_map modbus_rtu_server_map_inst (.clk_sys, .rst_b,
    .clk_en, .req_valid, .req, .wdata_valid, .wdata, .wdata_ready, .reply,
    .busy, .listen_only, .comm_restart, .status_word, .term_in_pin,
    .analog_in0, .analog_in1, .control_word, .relay_out, .profile);
  client_model client_model_inst (.clk_sys, .req_valid, .req, .wdata_valid,
    .wdata, .wdata_ready, .reply, .busy, .comm_restart);
  // =====================================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic gw(input int i, input logic [15:0] e);
    chk(client_model_inst.got[i], e);
  endtask
  // wcount fixed at one; data doubles as the combined write address
  task automatic rq(input logic [7:0] f, input logic [15:0] a, c, d);
    client_model_inst.issue({f, a, c, d, d, 16'h0001});
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // =====================================================================
  // scenarios
  task automatic t_coils;
    chk(profile, 2'h0);
    rq(8'h05, 16'h0020, 16'h0001, 16'hff00);
    chk(relay_out, 6'h01);
    rq(8'h05, 16'h0003, 16'h0001, 16'hff00);
    chk(control_word, 32'h8);
    rq(8'h01, 16'h0000, 16'h0010, 16'h0000);
    gw(0, 16'h0001);
    gw(1, 16'h0008);
    client_model_inst.wq = '{16'h002a};
    rq(8'h0f, 16'h0020, 16'h0006, 16'h0000);
    chk(relay_out, 6'h2a);
  endtask
  task automatic t_inputs;
    rq(8'h02, 16'h0000, 16'h0010, 16'h0000);
    gw(1, 16'h5678);
    rq(8'h02, 16'h0020, 16'h0006, 16'h0000);
    gw(1, 16'h0015);
    rq(8'h04, 16'h0000, 16'h0002, 16'h0000);
    gw(0, 16'h0002);
    gw(1, 16'h0abc);
    gw(2, 16'h0def);
  endtask
  task automatic t_regs;
    client_model_inst.wq = '{16'haaaa, 16'h5555};
    rq(8'h10, 16'h0004, 16'h0002, 16'h0000);
    rq(8'h03, 16'h0004, 16'h0002, 16'h0000);
    gw(1, 16'haaaa);
    gw(2, 16'h5555);
    rq(8'h06, 16'h0006, 16'h0001, 16'h1357);
    client_model_inst.wq = '{16'h2468};
    rq(8'h17, 16'h0006, 16'h0002, 16'h0007);
    gw(1, 16'h1357);
    gw(2, 16'h2468);
  endtask
  task automatic t_profiles;
    rq(8'h06, 16'h0001, 16'h0001, 16'h0002);
    rq(8'h06, 16'h0000, 16'h0001, 16'hffff);
    chk(profile, 2'h2);
    chk(control_word, modbus_map_pkg::MASK_FULL);
    rq(8'h06, 16'h0001, 16'h0001, 16'h0001);
    rq(8'h06, 16'h0000, 16'h0001, 16'hffff);
    chk(control_word, 32'hffff);
    rq(8'h02, 16'h0000, 16'h0020, 16'h0000);
    gw(2, 16'h1234);
    rq(8'h06, 16'h0002, 16'h0001, 16'h0001);
    chk(profile, 2'h3);
    rq(8'h06, 16'h0002, 16'h0001, 16'h0000);
    rq(8'h06, 16'h0001, 16'h0001, 16'h0000);
    chk(profile, 2'h0);
  endtask
  task automatic t_diag;
    rq(8'h08, 16'h0000, 16'h0001, 16'hbeef);
    gw(0, 16'hbeef);
    rq(8'h08, 16'h0004, 16'h0001, 16'h0000);
    chk(listen_only, 1'b1);
    rq(8'h03, 16'h0004, 16'h0001, 16'h0000);
    chk(client_model_inst.got.size(), 0);
    rq(8'h08, 16'h0001, 16'h0001, 16'h0000);
    chk(client_model_inst.saw_restart, 1'b1);
    chk(listen_only, 1'b0);
  endtask
  task automatic t_illegal;
    logic [7:0] bad[2];
    bad = '{8'h07, 8'h2b};
    rq(8'h06, 16'h0000, 16'h0001, 16'h0008);
    foreach (bad[i])
    begin
      rq(bad[i], 16'h0000, 16'h0001, 16'hffff);
      gw(0, {bad[i] | 8'h80, 8'h01});
      chk(control_word, 32'h8);
    end
  endtask
  // =====================================================================
  // clock, watchdog, main sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    wrap_up;
  end
  initial
  begin
    rst_b       = 1'b0;
    clk_en      = 1'b1;
    status_word = 32'h1234_5678;
    term_in_pin = 6'h15;
    analog_in0  = 16'h0abc;
    analog_in1  = 16'h0def;
    n_fail      = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_coils;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (3) @(posedge clk_sys);
    clk_en <= 1'b1;
    t_inputs;
    t_regs;
    t_profiles;
    t_diag;
    t_illegal;
    wrap_up;
  end
endmodule
`default_nettype wire
